// >>> rtl/crifp_map.vh
`ifndef CRIFP_MAP_VH
`define CRIFP_MAP_VH
// register byte offsets on the wishbone bus
`define CRIFP_FLAG_CTRL 8'h00
`define CRIFP_IRQ_STAT 8'h04
`define CRIFP_IRQ_MASK 8'h08
`define CRIFP_INTERRUPT_ACKNOWLEDGE_STROBE_CMD 8'h0C
`define CRIFP_INT_CFG 8'h10
`define CRIFP_BOOT_STAT 8'h14
`define CRIFP_BOOT_VEC 8'h18
// flag control field positions
`define CRIFP_F0_DIR 1
`define CRIFP_F0_OUT 2
`define CRIFP_F0_IN 3
`define CRIFP_F1_DIR 5
`define CRIFP_F1_OUT 6
`define CRIFP_F1_IN 7
// reset values
`define CRIFP_FLAG_RST 8'h00
`define CRIFP_MASK_RST 6'h00
`define CRIFP_CFG_RST 4'h0
// status event bits
`define CRIFP_EV_BOOT 4
`define CRIFP_EV_INTERRUPT_ACKNOWLEDGE_STROBE 5
// reset vector fetch timing
`define CRIFP_WS_MPROC 4'h7
`define CRIFP_WS_MCOMP 4'h0
`define CRIFP_FETCHES 2'h2
`define CRIFP_VEC_ADDR 24'h000000
`endif

// >>> rtl/crifp_top.v
`include "crifp_map.vh"

module crifp_top #(
  parameter ADDR_W = 24,
  parameter DATA_W = 32
) (
  input wire ref_clk,
  input wire rst_n,
  // wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  output reg irq_o,
  // flag pins, three signals each
  input wire flag_pin_zero_i,
  output reg flag_pin_zero_o,
  output reg flag_pin_zero_oe_n,
  input wire flag_pin_one_i,
  output reg flag_pin_one_o,
  output reg flag_pin_one_oe_n,
  // async-reset group of the serial port and timers
  output reg serial_timer_oe_n,
  // external interrupt lines, active low
  input wire [3:0] external_interrupt_lines_n,
  output reg interrupt_acknowledge_strobe_n,
  // external memory interface
  input wire boot_mode_select,
  output reg memory_strobe0_n,
  output reg memory_strobe1_n,
  output reg io_strobe_n,
  output reg rw_o,
  output reg rw_oe_n,
  output reg [ADDR_W-1:0] addr_o,
  output reg addr_oe_n,
  input wire [DATA_W-1:0] data_i,
  output reg data_oe_n
);

  // boot sequencer states
  localparam B_START = 2'b00;
  localparam B_STRB = 2'b01;
  localparam B_GAP = 2'b10;
  localparam B_DONE = 2'b11;

  reg [7:0] flag_ctrl_r; // flag control register
  reg [5:0] irq_stat_r; // sticky event bits
  reg [5:0] irq_mask_r; // interrupt enables
  reg [3:0] int_cfg_r; // 1 = edge, 0 = level per line
  reg [3:0] int_prev_r; // last line level for edges
  reg [1:0] boot_st_r; // boot sequencer state
  reg boot_mode_r; // boot select caught at release
  reg [3:0] ws_cnt_r; // wait states left in a fetch
  reg [1:0] fetch_cnt_r; // fetches completed
  reg [DATA_W-1:0] boot_vec_r; // last fetched vector
  reg interrupt_acknowledge_strobe_busy_r; // acknowledge cycle under way
  reg [3:0] interrupt_acknowledge_strobe_cnt_r; // acknowledge wait states left
  reg [5:0] ev_set; // events of this cycle
  reg [31:0] rd_mux; // read data selection
  wire wb_req; // new bus request this cycle
  wire wb_wr; // write with low byte enabled
  wire [3:0] int_act; // interrupt lines asserted
  wire [3:0] int_hit; // interrupts recognised

  // one answer per request; ack drops the cycle after
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // every writable field sits in byte lane 0
  assign wb_wr = wb_req & wb_we_i & wb_sel_i[0];
  assign int_act = ~external_interrupt_lines_n;

  // wait states for a fetch in the given boot mode
  function [3:0] fetch_ws;
    input mode;
    begin
      fetch_ws = mode ? `CRIFP_WS_MCOMP : `CRIFP_WS_MPROC;
    end
  endfunction

  // edge lines fire on a new assertion, level lines every cycle
  // a level pulse longer than one cycle is seen more than once
  // edge and level recognition
  assign int_hit = (int_cfg_r & int_act & ~int_prev_r) | (~int_cfg_r & int_act);

  // event collection feeding the sticky status
  always @* begin
    ev_set = {2'b00, int_hit};
    if (boot_st_r == B_STRB && ws_cnt_r == 4'h0 && fetch_cnt_r == 2'h1) begin
      ev_set[`CRIFP_EV_BOOT] = 1'b1;
    end
    if (interrupt_acknowledge_strobe_busy_r && interrupt_acknowledge_strobe_cnt_r == 4'h0) begin
      ev_set[`CRIFP_EV_INTERRUPT_ACKNOWLEDGE_STROBE] = 1'b1;
    end
  end

  // read data multiplexer, unmapped reads give zero
  always @* begin
    case (wb_adr_i)
      `CRIFP_FLAG_CTRL: rd_mux = {24'h000000, flag_ctrl_r};
      `CRIFP_IRQ_STAT: rd_mux = {26'h0000000, irq_stat_r};
      `CRIFP_IRQ_MASK: rd_mux = {26'h0000000, irq_mask_r};
      `CRIFP_INTERRUPT_ACKNOWLEDGE_STROBE_CMD: rd_mux = {27'h0000000, interrupt_acknowledge_strobe_busy_r, interrupt_acknowledge_strobe_cnt_r};
      `CRIFP_INT_CFG: rd_mux = {28'h0000000, int_cfg_r};
      `CRIFP_BOOT_STAT: rd_mux = {27'h0000000, boot_mode_r, boot_st_r, fetch_cnt_r};
      `CRIFP_BOOT_VEC: rd_mux = boot_vec_r;
      default: rd_mux = 32'h00000000;
    endcase
  end

  // bus slave handshake and read data
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req) begin
        wb_dat_o <= rd_mux;
      end
    end
  end

  // flag control register and pin sampling
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      flag_ctrl_r <= `CRIFP_FLAG_RST;
    end else begin
      if (wb_wr && wb_adr_i == `CRIFP_FLAG_CTRL) begin
        flag_ctrl_r[`CRIFP_F0_DIR] <= wb_dat_i[`CRIFP_F0_DIR];
        flag_ctrl_r[`CRIFP_F1_DIR] <= wb_dat_i[`CRIFP_F1_DIR];
        flag_ctrl_r[`CRIFP_F0_OUT] <= wb_dat_i[`CRIFP_F0_OUT];
        flag_ctrl_r[`CRIFP_F1_OUT] <= wb_dat_i[`CRIFP_F1_OUT];
      end
      // input bits are read only; they follow the pin only as inputs
      // input value
      if (!flag_ctrl_r[`CRIFP_F0_DIR]) begin
        flag_ctrl_r[`CRIFP_F0_IN] <= flag_pin_zero_i;
      end
      if (!flag_ctrl_r[`CRIFP_F1_DIR]) begin
        flag_ctrl_r[`CRIFP_F1_IN] <= flag_pin_one_i;
      end
    end
  end

  // flag pin drivers; reset releases them at the first edge
  // a synchronous reset cannot act without the clock edge
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      flag_pin_zero_oe_n <= 1'b1;
      flag_pin_one_oe_n <= 1'b1;
      flag_pin_zero_o <= 1'b0;
      flag_pin_one_o <= 1'b0;
      serial_timer_oe_n <= 1'b1;
    end else begin
      flag_pin_zero_o <= flag_ctrl_r[`CRIFP_F0_OUT];
      flag_pin_one_o <= flag_ctrl_r[`CRIFP_F1_OUT];
      flag_pin_zero_oe_n <= ~flag_ctrl_r[`CRIFP_F0_DIR];
      flag_pin_one_oe_n <= ~flag_ctrl_r[`CRIFP_F1_DIR];
      // serial and timer pins belong to other blocks once out of reset
      serial_timer_oe_n <= 1'b0;
    end
  end

  // interrupt status, mask, configuration and output
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      irq_stat_r <= 6'h00;
      irq_mask_r <= `CRIFP_MASK_RST;
      int_cfg_r <= `CRIFP_CFG_RST;
      int_prev_r <= 4'h0;
      irq_o <= 1'b0;
    end else begin
      int_prev_r <= int_act;
      // a new event beats a write-one clear of the same bit
      if (wb_wr && wb_adr_i == `CRIFP_IRQ_STAT) begin
        irq_stat_r <= (irq_stat_r & ~wb_dat_i[5:0]) | ev_set;
      end else begin
        irq_stat_r <= irq_stat_r | ev_set;
      end
      if (wb_wr && wb_adr_i == `CRIFP_IRQ_MASK) begin
        irq_mask_r <= wb_dat_i[5:0];
      end
      if (wb_wr && wb_adr_i == `CRIFP_INT_CFG) begin
        int_cfg_r <= wb_dat_i[3:0];
      end
      // one cycle behind the status so the pin is a flop
      irq_o <= |(irq_stat_r & irq_mask_r);
    end
  end

  // acknowledge strobe: one bus cycle plus its wait states
  // a write while busy or before boot has finished is dropped
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      interrupt_acknowledge_strobe_n <= 1'b1;
      interrupt_acknowledge_strobe_busy_r <= 1'b0;
      interrupt_acknowledge_strobe_cnt_r <= 4'h0;
    end else if (!interrupt_acknowledge_strobe_busy_r) begin
      if (wb_wr && wb_adr_i == `CRIFP_INTERRUPT_ACKNOWLEDGE_STROBE_CMD && boot_st_r == B_DONE) begin
        interrupt_acknowledge_strobe_n <= 1'b0;
        interrupt_acknowledge_strobe_busy_r <= 1'b1;
        interrupt_acknowledge_strobe_cnt_r <= wb_dat_i[3:0];
      end
    end else if (interrupt_acknowledge_strobe_cnt_r != 4'h0) begin
      interrupt_acknowledge_strobe_cnt_r <= interrupt_acknowledge_strobe_cnt_r - 4'h1;
    end else begin
      interrupt_acknowledge_strobe_n <= 1'b1;
      interrupt_acknowledge_strobe_busy_r <= 1'b0;
    end
  end

  // reset-vector fetch sequencer after release
  // sequence starts after release
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      boot_st_r <= B_START;
      boot_mode_r <= 1'b0;
      ws_cnt_r <= 4'h0;
      fetch_cnt_r <= 2'h0;
      boot_vec_r <= {DATA_W{1'b0}};
    end else begin
      case (boot_st_r)
        B_START: begin
          // boot select is caught once, at the first edge after release
          boot_mode_r <= boot_mode_select;
          ws_cnt_r <= fetch_ws(boot_mode_select);
          boot_st_r <= B_STRB;
        end
        B_STRB: begin
          if (ws_cnt_r != 4'h0) begin
            ws_cnt_r <= ws_cnt_r - 4'h1;
          end else begin
            boot_vec_r <= data_i;
            fetch_cnt_r <= fetch_cnt_r + 2'h1;
            if (fetch_cnt_r + 2'h1 == `CRIFP_FETCHES) begin
              boot_st_r <= B_DONE;
            end else begin
              boot_st_r <= B_GAP;
            end
          end
        end
        B_GAP: begin
          // strobe high for a cycle between the two fetches
          ws_cnt_r <= fetch_ws(boot_mode_r);
          boot_st_r <= B_STRB;
        end
        B_DONE: begin
          boot_st_r <= B_DONE;
        end
        default: begin
          boot_st_r <= B_START;
        end
      endcase
    end
  end

  // external bus pins, released or inactive during reset
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      memory_strobe0_n <= 1'b1;
      memory_strobe1_n <= 1'b1;
      io_strobe_n <= 1'b1;
      rw_o <= 1'b1;
      rw_oe_n <= 1'b1;
      addr_o <= {ADDR_W{1'b0}};
      addr_oe_n <= 1'b1;
      data_oe_n <= 1'b1;
    end else begin
      // fetches are reads: rw high and the data bus stays released
      rw_o <= 1'b1;
      rw_oe_n <= 1'b0;
      data_oe_n <= 1'b1;
      io_strobe_n <= 1'b1;
      memory_strobe1_n <= 1'b1;
      addr_o <= `CRIFP_VEC_ADDR;
      addr_oe_n <= (boot_st_r == B_DONE) ? 1'b1 : 1'b0;
      // strobe follows the sequencer state one edge later
      if (boot_st_r == B_START || boot_st_r == B_GAP) begin
        memory_strobe0_n <= 1'b0;
      end else if (boot_st_r == B_STRB && ws_cnt_r != 4'h0) begin
        memory_strobe0_n <= 1'b0;
      end else begin
        memory_strobe0_n <= 1'b1;
      end
    end
  end

endmodule // crifp_top

// >>> verification/cpu_reset_interrupt_flag_pins_bench.sv
module cpu_reset_interrupt_flag_pins_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 0, rst_n = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, boot_mode_select = 0;
  logic far_zero = 0, far_one = 0;
  logic [7:0] wb_adr_i = 8'h00, c, m;
  logic [3:0] wb_sel_i = 4'h1, external_interrupt_lines_n = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, data_i, q, mk;
  logic [23:0] addr_o;
  logic wb_ack_o, irq_o, flag_pin_zero_i, flag_pin_zero_o, flag_pin_zero_oe_n, flag_pin_one_i;
  logic flag_pin_one_o, flag_pin_one_oe_n, serial_timer_oe_n, interrupt_acknowledge_strobe_n;
  logic memory_strobe0_n, memory_strobe1_n, io_strobe_n, rw_o, rw_oe_n, addr_oe_n, data_oe_n;
  int fail_count = 0, comparisons = 0, cycles = 0;
  localparam logic [31:0] VEC = 32'h5A3C0F96; // arbitrary vector content
  always #20 ref_clk = ~ref_clk;
  crifp_top dut_u (.ref_clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq_o, .flag_pin_zero_i, .flag_pin_zero_o,
    .flag_pin_zero_oe_n, .flag_pin_one_i, .flag_pin_one_o, .flag_pin_one_oe_n,
    .serial_timer_oe_n, .external_interrupt_lines_n, .interrupt_acknowledge_strobe_n,
    .boot_mode_select, .memory_strobe0_n, .memory_strobe1_n, .io_strobe_n, .rw_o, .rw_oe_n,
    .addr_o, .addr_oe_n, .data_i, .data_oe_n);
  crifp_partner #(.VEC(VEC)) far_u (.ref_clk, .flag_pin_zero_o, .flag_pin_zero_oe_n,
    .flag_pin_one_o, .flag_pin_one_oe_n, .far_zero, .far_one, .memory_strobe0_n,
    .flag_pin_zero_i, .flag_pin_one_i, .data_i);
  // one compare for every result
  task chk(input string what, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", what, e, g);
    end
  endtask
  // classic cycle; read data is taken at the ack edge, released only after it
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    // no cycle count is assumed; the wait runs until ack, bounded only by the hang guard
    do begin
      @(posedge ref_clk);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
  endtask
  task print_verdict;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // expected flag control read-back from written bits and outside levels
  function logic [7:0] ctl_exp(input logic [7:0] w, input logic i0, input logic i1);
    return {i1, w[6:5], 1'b0, i0, w[2:1], 1'b0};
  endfunction
  // hang guard, far above the few hundred cycles the tests need
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      print_verdict;
    end
  end
  initial begin
    void'($urandom(5));
    // both boot modes, the second reset lands after the first boot has finished
    for (int b = 0; b < 2; b++) begin
      rst_n <= 0;
      boot_mode_select <= b[0];
      repeat (12) @(posedge ref_clk);
      chk("addr in reset", 32'h0, {8'h00, addr_o});
      chk("rw in reset", 32'h3, {30'h0, rw_o, rw_oe_n});
      chk("pins in reset", 32'h7, {29'h0, flag_pin_zero_oe_n, flag_pin_one_oe_n, serial_timer_oe_n});
      rst_n <= 1;
      repeat (40) @(posedge ref_clk);
      chk("bus after boot", 32'h3, {29'h0, rw_oe_n, addr_oe_n, data_oe_n});
      chk("side pins after boot", 32'h6, {29'h0, memory_strobe1_n, io_strobe_n, serial_timer_oe_n});
      chk("read level after boot", 32'h1, {31'h0, rw_o});
      wb(0, 8'h04, 0);
      chk("boot event", 32'h10, q);
      wb(0, 8'h18, 0);
      chk("boot vector", VEC, q);
      wb(1, 8'h04, 32'h10);
    end
    // random directions, values and outside levels on both flag pins
    repeat (20) begin
      c = 8'($urandom) & 8'h66;
      m = {~c[5], 3'h7, ~c[1], 3'h7}; // an input bit holds while its pin drives
      far_zero <= 1'($urandom);
      far_one <= 1'($urandom);
      wb(1, 8'h00, {24'h0, c});
      repeat (3) @(posedge ref_clk);
      chk("pin0 oe", {31'h0, ~c[1]}, {31'h0, flag_pin_zero_oe_n});
      chk("pin1 oe", {31'h0, ~c[5]}, {31'h0, flag_pin_one_oe_n});
      chk("pin0 level", {31'h0, c[1] ? c[2] : far_zero}, {31'h0, flag_pin_zero_i});
      chk("pin1 level", {31'h0, c[5] ? c[6] : far_one}, {31'h0, flag_pin_one_i});
      wb(0, 8'h00, 0);
      chk("flag ctrl", {24'h0, ctl_exp(c, far_zero, far_one) & m}, q & {24'h0, m});
    end
    // every line in level then edge mode, one-cycle pulse, mask chosen at random
    for (int i = 0; i < 8; i++) begin
      mk = {31'h0, 1'($urandom)};
      wb(1, 8'h10, (i < 4) ? 32'h0 : 32'hF);
      wb(1, 8'h08, mk << (i % 4));
      external_interrupt_lines_n[i % 4] <= 1'b0;
      @(posedge ref_clk);
      external_interrupt_lines_n[i % 4] <= 1'b1;
      repeat (3) @(posedge ref_clk);
      chk("irq", mk, {31'h0, irq_o});
      wb(0, 8'h04, 0);
      chk("int status", 32'h1 << (i % 4), q);
      wb(1, 8'h04, 32'h1 << (i % 4));
      wb(0, 8'h04, 0);
      chk("status clear", 32'h0, q);
    end
    // acknowledge with no waits, the longest wait, and a random one
    for (int k = 0; k < 3; k++) begin
      wb(1, 8'h0C, (k == 0) ? 32'h0 : (k == 1) ? 32'hF : 32'($urandom % 16));
      repeat (20) @(posedge ref_clk);
      wb(0, 8'h04, 0);
      chk("ack event", 32'h20, q);
      wb(1, 8'h04, 32'h20);
    end
    // unmapped place reads zero
    wb(0, 8'h1C, 0);
    chk("unmapped", 32'h0, q);
    print_verdict;
  end
endmodule // cpu_reset_interrupt_flag_pins_bench

// >>> verification/crifp_partner.sv
module crifp_partner #(
  parameter logic [31:0] VEC = 32'h5A3C0F96
) (
  input wire ref_clk,
  input wire flag_pin_zero_o,
  input wire flag_pin_zero_oe_n,
  input wire flag_pin_one_o,
  input wire flag_pin_one_oe_n,
  input wire far_zero,
  input wire far_one,
  input wire memory_strobe0_n,
  output logic flag_pin_zero_i,
  output logic flag_pin_one_i,
  output logic [31:0] data_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] junk_r = 32'h0; // idle bus content, changes every cycle
  // wire level: the outside drives only while the pin is released
  assign flag_pin_zero_i = flag_pin_zero_oe_n ? far_zero : flag_pin_zero_o;
  assign flag_pin_one_i = flag_pin_one_oe_n ? far_one : flag_pin_one_o;
  // memory answers only while selected; otherwise garbage so a stale capture shows
  assign data_i = memory_strobe0_n ? junk_r : VEC;
  always @(posedge ref_clk) begin
    junk_r <= ~junk_r;
  end
endmodule // crifp_partner

// >>> verification/crifp_props.sv
module crifp_props (
  input wire ref_clk,
  input wire rst_n,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire wb_ack_o,
  input wire flag_pin_zero_oe_n,
  input wire flag_pin_one_oe_n,
  input wire serial_timer_oe_n,
  input wire interrupt_acknowledge_strobe_n,
  input wire boot_mode_select,
  input wire memory_strobe0_n,
  input wire memory_strobe1_n,
  input wire io_strobe_n,
  input wire rw_oe_n,
  input wire addr_oe_n,
  input wire data_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  wire cmd; // acknowledge command write on the bus
  logic [3:0] ws_r; // wait field of the last accepted command
  logic [4:0] ack_cnt_r; // low cycles of the acknowledge strobe
  logic [3:0] s0_cnt_r; // low cycles of the fetch strobe
  assign cmd = wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && !wb_ack_o && wb_adr_i == 8'h0C;
  // counters restart whenever the strobe is high, so reset needs no extra term
  always @(posedge ref_clk) begin
    ack_cnt_r <= interrupt_acknowledge_strobe_n ? 5'h00 : ack_cnt_r + 5'h01;
    s0_cnt_r <= memory_strobe0_n ? 4'h0 : s0_cnt_r + 4'h1;
    if (cmd && interrupt_acknowledge_strobe_n) begin
      ws_r <= wb_dat_i[3:0];
    end
  end
  // reset checks carry no disable: reset is the cause they test
  chk_async_pins_off: assert property (@(posedge ref_clk) !rst_n |=>
    flag_pin_zero_oe_n && flag_pin_one_oe_n && serial_timer_oe_n) else $error("pins driven in reset");
  chk_strobes_high: assert property (@(posedge ref_clk) !rst_n |=>
    memory_strobe0_n && memory_strobe1_n && io_strobe_n) else $error("strobe low in reset");
  chk_bus_released: assert property (@(posedge ref_clk) !rst_n |=>
    addr_oe_n && data_oe_n) else $error("bus driven in reset");
  chk_rw_released: assert property (@(posedge ref_clk) !rst_n |=> rw_oe_n)
    else $error("rw driven in reset");
  chk_interrupt_acknowledge_strobe_reset: assert property (@(posedge ref_clk) !rst_n |=> interrupt_acknowledge_strobe_n)
    else $error("ack strobe low in reset");
  chk_interrupt_acknowledge_strobe_cause: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $fell(interrupt_acknowledge_strobe_n) |-> $past(cmd)) else $error("ack strobe without command");
  chk_interrupt_acknowledge_strobe_length: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(interrupt_acknowledge_strobe_n) |-> ack_cnt_r == {1'b0, ws_r} + 5'h01)
    else $error("ack strobe length wrong");
  chk_fetch_waits: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(memory_strobe0_n) |-> s0_cnt_r == (boot_mode_select ? 4'h1 : 4'h8))
    else $error("fetch wait states wrong");
  chk_bus_ack_once: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o) else $error("bus ack timing");
endmodule // crifp_props

bind crifp_top crifp_props u_props (.ref_clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_sel_i, .wb_dat_i, .wb_ack_o, .flag_pin_zero_oe_n, .flag_pin_one_oe_n, .serial_timer_oe_n,
  .interrupt_acknowledge_strobe_n, .boot_mode_select, .memory_strobe0_n, .memory_strobe1_n,
  .io_strobe_n, .rw_oe_n, .addr_oe_n, .data_oe_n);
